// *** shared/cfs_pkg.sv ***
package cfs_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the Avalon-MM slave
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CMD     = 5'h00;
  localparam logic [4:0] OFS_QUEUE   = 5'h04;
  localparam logic [4:0] OFS_REDUND  = 5'h08;
  localparam logic [4:0] OFS_BITFRM  = 5'h0c;
  localparam logic [4:0] OFS_RXDELAY = 5'h10;
  localparam logic [4:0] OFS_LEVEL   = 5'h14;
  localparam logic [4:0] OFS_STATUS  = 5'h18;
  localparam logic [4:0] OFS_FLAGS   = 5'h1c;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_IDLE = 6'h00;
  localparam logic [5:0] CMD_TX   = 6'h1a;
  localparam logic [5:0] CMD_RX   = 6'h16;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLG_TX       = 0;
  localparam int FLG_RX       = 1;
  localparam int FLG_IDLE     = 2;
  localparam int STAT_EMPTY   = 4;
  localparam int STAT_CNT_LSB = 8;
  localparam logic [7:0]  RXDELAY_RST = 8'h06;
  localparam logic [3:0]  LEVEL_RST   = 4'h4;
  localparam logic [15:0] CRC_POLY    = 16'h8408;
  localparam logic [15:0] CRC_INIT    = 16'h6363;

  // ----------------------------------------------------------------
  // Link phase codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PH_IDLE      = 3'h0;
  localparam logic [2:0] PH_TX_SOF    = 3'h1;
  localparam logic [2:0] PH_TX_DATA   = 3'h2;
  localparam logic [2:0] PH_TX_EOF    = 3'h3;
  localparam logic [2:0] PH_RX_WAIT   = 3'h4;
  localparam logic [2:0] PH_RX_LISTEN = 3'h5;
  localparam logic [2:0] PH_RX_DATA   = 3'h6;
  localparam logic [2:0] PH_TX_ARM    = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS  = 40;
  localparam int BIT_NS  = 9440;
  localparam int BIT_CYC = BIT_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_TX_ARM, S_TX_SOF, S_TX_DATA, S_TX_EOF, S_RX_WAIT, S_RX_LISTEN, S_RX_DATA
  } cfs_state_t;

  typedef struct packed {
    logic tx_crc_append;
    logic parity_sense;
    logic parity_on;
  } cfs_cfg_t;

  typedef struct packed {
    logic tx_bit;
    logic tx_active;
    logic rx_prepare;
    logic rx_enable;
  } cfs_rf_out_t;

  typedef struct packed {
    logic [3:0] level;
    logic       data;
  } cfs_rf_in_t;

endpackage

// *** rtl/cfs_sequencer.sv ***
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module cfs_sequencer #(
  parameter int BIT_CYCLES = cfs_pkg::BIT_CYC,
  parameter int FIFO_DEPTH = 64
) (
  // Clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_nrst,
  // Avalon-MM slave
  input  wire logic [4:0]          i_address,
  input  wire logic                i_read,
  input  wire logic                i_write,
  input  wire logic [31:0]         i_writedata,
  output logic      [31:0]         o_readdata,
  output logic                     o_waitrequest,
  // RF front end
  input  wire cfs_pkg::cfs_rf_in_t i_rf,
  output cfs_pkg::cfs_rf_out_t     o_rf
);
  import cfs_pkg::*;
  localparam int AW = $clog2(FIFO_DEPTH);

  function automatic logic par_bit(input logic [7:0] b, input logic odd);
    par_bit = (^b) ^ odd;
  endfunction
  function automatic logic in_prep(input logic [7:0] c);
    in_prep = (c != 8'h00) && (c <= 8'h03);
  endfunction
  function automatic logic [2:0] phase_of(input cfs_state_t s);
    case (s)
      S_TX_ARM:    phase_of = PH_TX_ARM;
      S_TX_SOF:    phase_of = PH_TX_SOF;
      S_TX_DATA:   phase_of = PH_TX_DATA;
      S_TX_EOF:    phase_of = PH_TX_EOF;
      S_RX_WAIT:   phase_of = PH_RX_WAIT;
      S_RX_LISTEN: phase_of = PH_RX_LISTEN;
      S_RX_DATA:   phase_of = PH_RX_DATA;
      default:     phase_of = PH_IDLE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic              wait_q, pbit, accept;
  logic [5:0]        cmd;
  cfs_cfg_t          cfg;
  logic [2:0]        partial, flags;
  logic [7:0]        rx_delay, shreg, rx_cnt, rsh;
  logic [3:0]        min_level, idx, blen, ndat;
  logic [7:0]        mem [FIFO_DEPTH];
  logic [AW-1:0]     wptr, rptr;
  logic [AW:0]       count;
  cfs_state_t        state;
  logic [15:0]       div, crc;
  logic [1:0]        crc_stage;
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Every access takes two cycles: waitrequest is high in the first,
  // low in the second, so read data is always registered.
  wire       taken   = (i_read || i_write) && !wait_q;
  wire       wr_ok   = i_write && taken;
  wire       rd_ok   = i_read && taken;
  wire       cmd_wr  = wr_ok && (i_address == OFS_CMD);
  wire       q_wr    = wr_ok && (i_address == OFS_QUEUE);
  wire       cfg_wr  = wr_ok && (i_address == OFS_REDUND);
  wire       bf_wr   = wr_ok && (i_address == OFS_BITFRM);
  wire       dly_wr  = wr_ok && (i_address == OFS_RXDELAY);
  wire       lvl_wr  = wr_ok && (i_address == OFS_LEVEL);
  wire       flg_wr  = wr_ok && (i_address == OFS_FLAGS);
  wire       q_rd    = rd_ok && (i_address == OFS_QUEUE);
  wire [5:0] new_cmd = i_writedata[5:0];
  wire          fifo_empty = (count == '0);
  wire          fifo_full  = (count == (AW + 1)'(FIFO_DEPTH));
  wire [7:0]    head       = mem[rptr];
  wire [31:0]   status     = (32'(count) << STAT_CNT_LSB) | (32'(fifo_empty) << STAT_EMPTY)
                             | 32'(phase_of(state));
  wire [31:0]   next_rdata = (i_address == OFS_CMD)     ? 32'(cmd) :
                             (i_address == OFS_QUEUE)   ? 32'(head) :
                             (i_address == OFS_REDUND)  ? 32'(cfg) :
                             (i_address == OFS_BITFRM)  ? 32'(partial) :
                             (i_address == OFS_RXDELAY) ? 32'(rx_delay) :
                             (i_address == OFS_LEVEL)   ? 32'(min_level) :
                             (i_address == OFS_STATUS)  ? status :
                             (i_address == OFS_FLAGS)   ? 32'(flags) : 32'h0000_0000;
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wait_q     <= 1'b1;
      o_readdata <= 32'h0000_0000;
    end else begin
      wait_q     <= !((i_read || i_write) && wait_q);
      o_readdata <= next_rdata;
    end
  end
  assign o_waitrequest = wait_q;
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cfg       <= '0;
      rx_delay  <= RXDELAY_RST;
      min_level <= LEVEL_RST;
    end else begin
      if (cfg_wr) cfg <= i_writedata[2:0];
      if (dly_wr) rx_delay <= i_writedata[7:0];
      if (lvl_wr) min_level <= i_writedata[3:0];
    end
  end
  // ----------------------------------------------------------------
  // Bit clock and datapath wires
  // ----------------------------------------------------------------
  wire       tick     = (div == 16'(BIT_CYCLES - 1));
  wire       above    = (i_rf.level > min_level);
  wire       byte_end = (idx == blen - 4'd1);
  wire       more_crc = cfg.tx_crc_append && (crc_stage != 2'd2);
  wire       tx_now   = (idx < ndat) ? shreg[idx[2:0]] : pbit;
  wire       crc_en   = (state == S_TX_DATA) && (crc_stage == 2'd0) && (idx < ndat);
  wire [15:0] crc_upd = {1'b0, crc[15:1]} ^ ((crc[0] ^ tx_now) ? CRC_POLY : 16'h0000);
  wire [15:0] crc_nx  = crc_en ? crc_upd : crc;
  wire       from_q   = (state == S_TX_SOF) || accept;
  wire       last_ld  = (count == (AW + 1)'(1));
  // partial length applies to a byte that empties the queue.
  wire [3:0] ld_nd    = (from_q && last_ld && partial != 3'h0) ? {1'b0, partial} : 4'd8;
  // parity only follows a full byte.
  wire [3:0] ld_len   = ld_nd + {3'h0, (ld_nd == 4'd8) && cfg.parity_on};
  wire [7:0] ld_byte  = from_q ? head : ((crc_stage == 2'd0) ? crc_nx[7:0] : crc[15:8]);
  wire       tx_pop   = !cmd_wr && tick && ((state == S_TX_SOF)
                        || ((state == S_TX_DATA) && byte_end && accept));
  wire       tx_fin   = !cmd_wr && tick && (state == S_TX_EOF) && (idx != 4'd0);
  wire       rx_end   = (idx == (cfg.parity_on ? 4'd8 : 4'd7));
  wire [7:0] rx_byte  = (idx == 4'd8) ? rsh : {i_rf.data, rsh[7:1]};
  wire       rx_push  = !cmd_wr && tick && (state == S_RX_DATA) && above && rx_end;
  wire       rx_fin   = !cmd_wr && tick && (state == S_RX_DATA) && !above;
  always_ff @(posedge i_clock) begin
    if (!i_nrst || tick) div <= 16'h0000;
    else div <= div + 16'h0001;
  end
  // ----------------------------------------------------------------
  // Queue
  // ----------------------------------------------------------------
  // A decoder byte wins over a bus write in the same cycle; the bus
  // byte is then lost, which software avoids by not writing during receive.
  wire       push  = (rx_push || q_wr) && !fifo_full;
  wire       pop   = (q_rd || tx_pop) && !fifo_empty;
  wire [7:0] pdata = rx_push ? rx_byte : i_writedata[7:0];
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        mem[wptr] <= pdata;
        wptr      <= wptr + 1'b1;
      end
      if (pop) rptr <= rptr + 1'b1;
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  // Set wins over a write-one-to-clear in the same cycle.
  logic [2:0] flag_set;
  assign flag_set[FLG_TX]   = tx_fin;
  assign flag_set[FLG_RX]   = rx_fin;
  assign flag_set[FLG_IDLE] = tx_fin || rx_fin;
  always_ff @(posedge i_clock) begin
    if (!i_nrst) flags <= 3'h0;
    else flags <= (flags & ~(flg_wr ? i_writedata[2:0] : 3'h0)) | flag_set;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state     <= S_IDLE;
      cmd       <= CMD_IDLE;
      partial   <= 3'h0;
      o_rf      <= '0;
      shreg     <= 8'h00;
      pbit      <= 1'b0;
      idx       <= 4'h0;
      blen      <= 4'h8;
      ndat      <= 4'h8;
      accept    <= 1'b0;
      crc       <= CRC_INIT;
      crc_stage <= 2'd0;
      rx_cnt    <= 8'h00;
      rsh       <= 8'h00;
    end else if (cmd_wr) begin
      // any command write retargets the sequencer at once
      o_rf      <= '0;
      idx       <= 4'h0;
      crc       <= CRC_INIT;
      crc_stage <= 2'd0;
      accept    <= 1'b0;
      case (new_cmd)
        CMD_TX: begin
          cmd   <= CMD_TX;
          state <= fifo_empty ? S_TX_ARM : S_TX_SOF;
        end
        CMD_RX: begin
          cmd          <= CMD_RX;
          state        <= S_RX_WAIT;
          rx_cnt       <= rx_delay;
          o_rf.rx_prepare <= in_prep(rx_delay);
        end
        default: begin
          cmd   <= CMD_IDLE;
          state <= S_IDLE;
        end
      endcase
    end else begin
      if (bf_wr) partial <= i_writedata[2:0];
      case (state)
        S_IDLE: begin
          o_rf <= '0;
        end
        S_TX_ARM: begin
          if (!fifo_empty) state <= S_TX_SOF;
        end
        S_TX_SOF: begin
          if (tick) begin
            o_rf.tx_active <= 1'b1;
            o_rf.tx_bit    <= 1'b1;
            shreg          <= ld_byte;
            pbit           <= par_bit(ld_byte, cfg.parity_sense);
            ndat           <= ld_nd;
            blen           <= ld_len;
            accept         <= !last_ld;
            idx            <= 4'h0;
            state          <= S_TX_DATA;
          end
        end
        S_TX_DATA: begin
          if (tick) begin
            o_rf.tx_bit <= tx_now;
            crc <= crc_nx;
            // empty check one bit early; parity counts in blen
            if (crc_stage == 2'd0 && blen >= 4'd2 && idx == blen - 4'd2)
              accept <= !fifo_empty;
            if (byte_end) begin
              idx <= 4'h0;
              if (accept || more_crc) begin
                shreg  <= ld_byte;
                pbit   <= par_bit(ld_byte, cfg.parity_sense);
                ndat   <= ld_nd;
                blen   <= ld_len;
                accept <= accept && !last_ld;
                if (!accept) crc_stage <= crc_stage + 2'd1;
              end else begin
                state <= S_TX_EOF;
              end
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
        S_TX_EOF: begin
          if (tick) begin
            if (idx == 4'h0) begin
              o_rf.tx_bit <= 1'b0;
              idx         <= 4'h1;
            end else begin
              // partial count cleared; back to idle
              o_rf.tx_active <= 1'b0;
              partial        <= 3'h0;
              cmd            <= CMD_IDLE;
              state          <= S_IDLE;
            end
          end
        end
        S_RX_WAIT: begin
          if (tick) begin
            // prepare at 3..1, monitor at 0
            if (rx_cnt == 8'h00) begin
              o_rf.rx_prepare <= 1'b0;
              o_rf.rx_enable  <= 1'b1;
              state           <= S_RX_LISTEN;
            end else begin
              rx_cnt          <= rx_cnt - 8'h01;
              o_rf.rx_prepare <= in_prep(rx_cnt - 8'h01);
            end
          end
        end
        S_RX_LISTEN: begin
          // decode only above level; await start pattern
          if (tick && above && i_rf.data) begin
            idx   <= 4'h0;
            state <= S_RX_DATA;
          end
        end
        S_RX_DATA: begin
          if (tick) begin
            if (!above) begin
              o_rf.rx_enable <= 1'b0;
              cmd            <= CMD_IDLE;
              state          <= S_IDLE;
            end else begin
              // bytes go to queue; LSB first
              if (idx != 4'd8) rsh <= {i_rf.data, rsh[7:1]};
              idx <= rx_end ? 4'h0 : idx + 4'h1;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence s_armed_empty;
    (state == S_TX_ARM) && fifo_empty && !cmd_wr;
  endsequence
  sequence s_armed_fed;
    (state == S_TX_ARM) && !fifo_empty && !cmd_wr;
  endsequence

  a_tx_only_write: assert property ((state == S_IDLE) && !cmd_wr |=> (state == S_IDLE))
    else $error("sequencer left idle without a command write");
  a_arm_holds: assert property (s_armed_empty |=> (state == S_TX_ARM) && !o_rf.tx_active)
    else $error("armed transmit started on empty queue");
  a_arm_release: assert property (s_armed_fed ##1 !cmd_wr |-> (state == S_TX_SOF))
    else $error("armed transmit did not start after data");
  a_halt_next: assert property (
    cmd_wr && (new_cmd != CMD_TX) |=> !o_rf.tx_active && (state != S_TX_DATA))
    else $error("transmit not halted on next cycle");
  a_sof_first: assert property (
    $rose(o_rf.tx_active) |-> o_rf.tx_bit && ($past(state) == S_TX_SOF))
    else $error("frame did not open with start pattern");
  a_tx_done_flag: assert property (
    tx_fin |=> flags[FLG_TX] && flags[FLG_IDLE] && (state == S_IDLE) && (cmd == CMD_IDLE))
    else $error("transmit completion flags not set");
  a_partial_clear: assert property (tx_fin && !bf_wr |=> (partial == 3'h0))
    else $error("partial bit count not cleared");
  a_accept_check: assert property (
    tick && !cmd_wr && (state == S_TX_DATA) && (crc_stage == 2'd0) && (blen >= 4'd2)
    && (idx == blen - 4'd2) |=> (accept == $past(!fifo_empty)))
    else $error("accept-more not sampled one bit early");
  a_rx_listen: assert property (
    $rose(o_rf.rx_enable) |-> ($past(state) == S_RX_WAIT) && ($past(rx_cnt) == 8'h00))
    else $error("monitoring began before delay reached zero");
  a_rx_done_flag: assert property (
    rx_fin |=> flags[FLG_RX] && flags[FLG_IDLE] && !o_rf.rx_enable && (state == S_IDLE))
    else $error("receive completion not flagged");
  a_parity_len: assert property (
    tick && !cmd_wr && (state == S_TX_SOF) && cfg.parity_on && (ld_nd == 4'd8)
    |=> (blen == 4'd9))
    else $error("full byte lacks parity slot");

endmodule

// *** tb/cfs_card_model.sv ***
`timescale 1ns/1ps
module cfs_card_model #(
  parameter int         BIT_CYCLES = 4,
  parameter logic [7:0] RESP_BYTE  = 8'h3c
) (
  // Clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_nrst,
  // Reader side of the link
  input  wire cfs_pkg::cfs_rf_out_t i_rf_out,
  output cfs_pkg::cfs_rf_in_t       o_rf_in,
  // Captured reader frame
  output logic [31:0]               o_tx_bits,
  output logic [5:0]                o_tx_count
);
  import cfs_pkg::*;
  logic       was_active;
  logic       was_enable;
  logic       tog = 1'b0;
  int         tx_phase;
  int         rx_phase = -1;
  int         idx;
  logic [8:0] frame;
  assign idx   = rx_phase / BIT_CYCLES;
  assign frame = {RESP_BYTE, 1'b1};
  // start then data.
  // Each value is held one bit time, so every decoder tick sees exactly one bit.
  assign o_rf_in.level = (rx_phase >= 0 && idx < 9) ? 4'h9 : 4'h0;
  assign o_rf_in.data  = (rx_phase >= 0 && idx < 9) ? frame[idx[3:0]] : tog;
  always_ff @(posedge i_clock) begin
    tog        <= ~tog;
    was_active <= i_rf_out.tx_active;
    was_enable <= i_rf_out.rx_enable;
    if (!i_nrst) begin
      rx_phase   <= -1;
      o_tx_count <= 6'h00;
      o_tx_bits  <= 32'h0;
    end else begin
      // Sample the reader line mid-bit, away from the tick that changes it.
      if (i_rf_out.tx_active && !was_active) begin
        tx_phase   <= 1;
        o_tx_count <= 6'h00;
        o_tx_bits  <= 32'h0;
      end else if (i_rf_out.tx_active) begin
        if (tx_phase % BIT_CYCLES == 1) begin
          o_tx_bits[o_tx_count[4:0]] <= i_rf_out.tx_bit;
          o_tx_count                 <= o_tx_count + 6'h01;
        end
        tx_phase <= tx_phase + 1;
      end
      if (i_rf_out.rx_enable && !was_enable) begin
        rx_phase <= 0;
      end else if (rx_phase >= 0 && rx_phase < 40) begin
        rx_phase <= rx_phase + 1;
      end else if (!i_rf_out.rx_enable) begin
        rx_phase <= -1;
      end
    end
  end
endmodule

// *** tb/card_frame_tx_rx_sequencer_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module card_frame_tx_rx_sequencer_tb;
  import cfs_pkg::*;
  localparam int BC = 4;
  logic        i_clock;
  logic        i_nrst;
  logic        i_read;
  logic        i_write;
  logic [4:0]  i_address;
  logic [31:0] i_writedata;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic [31:0] rd;
  cfs_rf_in_t  i_rf;
  cfs_rf_out_t o_rf;
  logic [31:0] tx_bits;
  logic [5:0]  tx_count;
  int          fail_count;
  int          num_checks;

  cfs_sequencer #(.BIT_CYCLES(BC), .FIFO_DEPTH(64)) dut (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_rf(i_rf), .o_rf(o_rf));
  cfs_card_model #(.BIT_CYCLES(BC), .RESP_BYTE(8'h3c)) card (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_rf_out(o_rf), .o_rf_in(i_rf), .o_tx_bits(tx_bits),
    .o_tx_count(tx_count));

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // Avalon-MM master
  // -------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_write     <= w;
    i_read      <= !w;
    i_address   <= a;
    i_writedata <= d;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) fail_count++;
    rd = o_readdata;
    i_write <= 1'b0;
    i_read  <= 1'b0;
  endtask

  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_FLAGS, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 100);
    if (rd[b] !== 1'b1) fail_count++;
  endtask

  task automatic tx_check(input logic [31:0] exp_bits, input logic [5:0] exp_n);
    wait_flag(FLG_TX);
    `CHK("frame bits", exp_bits, tx_bits)
    `CHK("frame length", exp_n, tx_count)
    `CHK("flags", 32'h5, rd)
    bus(1'b0, OFS_CMD, 32'h0);
    `CHK("command", 32'h0, rd)
    bus(1'b1, OFS_FLAGS, 32'h7);
  endtask

  initial begin
    // Far longer than the whole sequence, which needs well under a thousand cycles.
    repeat (20000) @(posedge i_clock);
    fail_count++;
    complete_run();
  end

  initial begin
    fail_count = 0;
    num_checks = 0;
    i_nrst = 1'b0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_address = 5'h00;
    i_writedata = 32'h0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    bus(1'b0, OFS_RXDELAY, 32'h0);
    `CHK("receiver_delay", {24'h0, RXDELAY_RST}, rd)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("status", 32'h10, rd)
    bus(1'b0, 5'h02, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
    bus(1'b1, OFS_QUEUE, 32'ha5);
    repeat (12) @(posedge i_clock);
    `CHK("no autostart", 1'b0, o_rf.tx_active)
    bus(1'b1, OFS_CMD, {26'h0, CMD_TX});
    tx_check({22'h0, 1'b0, 8'ha5, 1'b1}, 6'd10);
    $display("test single byte done");
    bus(1'b1, OFS_REDUND, 32'h3);
    bus(1'b1, OFS_BITFRM, 32'h4);
    bus(1'b1, OFS_QUEUE, 32'h01);
    bus(1'b1, OFS_QUEUE, 32'h0f);
    bus(1'b1, OFS_CMD, {26'h0, CMD_TX});
    tx_check({17'h0, 1'b0, 4'hf, 1'b0, 8'h01, 1'b1}, 6'd15);
    bus(1'b0, OFS_BITFRM, 32'h0);
    `CHK("partial count", 32'h0, rd)
    $display("test partial done");
    bus(1'b1, OFS_REDUND, 32'h1);
    bus(1'b1, OFS_CMD, {26'h0, CMD_TX});
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("armed status", 32'h17, rd)
    `CHK("armed line", 1'b0, o_rf.tx_active)
    bus(1'b1, OFS_QUEUE, 32'h83);
    bus(1'b1, OFS_QUEUE, 32'h42);
    tx_check({12'h0, 1'b0, 1'b0, 8'h42, 1'b1, 8'h83, 1'b1}, 6'd20);
    $display("test streaming done");
    bus(1'b1, OFS_REDUND, 32'h4);
    bus(1'b1, OFS_QUEUE, 32'h00);
    bus(1'b1, OFS_CMD, {26'h0, CMD_TX});
    tx_check({6'h0, 1'b0, 8'h51, 8'hfe, 8'h00, 1'b1}, 6'd26);
    bus(1'b1, OFS_REDUND, 32'h0);
    $display("test crc done");
    bus(1'b1, OFS_RXDELAY, 32'h3);
    bus(1'b1, OFS_CMD, {26'h0, CMD_RX});
    #1;
    `CHK("rx prepare", 1'b1, o_rf.rx_prepare)
    wait_flag(FLG_RX);
    `CHK("rx flags", 32'h6, rd)
    bus(1'b0, OFS_QUEUE, 32'h0);
    `CHK("rx byte", 32'h3c, rd)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("rx status", 32'h10, rd)
    bus(1'b1, OFS_FLAGS, 32'h7);
    $display("test receive done");
    bus(1'b1, OFS_QUEUE, 32'h11);
    bus(1'b1, OFS_QUEUE, 32'h22);
    bus(1'b1, OFS_CMD, {26'h0, CMD_TX});
    for (int n = 0; n < 40 && o_rf.tx_active !== 1'b1; n++) @(posedge i_clock);
    bus(1'b1, OFS_CMD, {26'h0, CMD_IDLE});
    #1;
    `CHK("halt", 1'b0, o_rf.tx_active)
    bus(1'b0, OFS_FLAGS, 32'h0);
    `CHK("halt flags", 32'h0, rd)
    $display("test halt done");
    complete_run();
  end
endmodule
